/* File: core/stw_params.svh */
`ifndef STW_PARAMS_SVH
`define STW_PARAMS_SVH

// ------------------------------------------------------------
// link framing
// ------------------------------------------------------------
`define STW_BYTE_BITS 4'h8
`define STW_ADDR_OK 3'h0
`define STW_RESET_EDGES 4'h9
`define STW_FIFO_DEPTH 4

`endif

/* File: core/stw_pkg.sv */
package stw_pkg;
  // link states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD = 5'h02,
    ST_ACK = 5'h04,
    ST_SEND = 5'h08,
    ST_HACK = 5'h10
  } stw_state_t;
endpackage

/* File: core/stw_link.sv */
`timescale 1ns/10ps
`include "stw_params.svh"

// ------------------------------------------------------------
// small fifo
// ------------------------------------------------------------
module stw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `STW_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rp_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    wp_d = push ? bump(wp_q) : wp_q;
    rp_d = pop ? bump(rp_q) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wp_q] <= in_data_in;
    end
  end
endmodule

// ------------------------------------------------------------
// two-wire bit layer, device end
// ------------------------------------------------------------
module stw_link (
  // system clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // link pins
  input wire logic sck_in,
  input wire logic dat_in,
  output logic dat_out,
  output logic dat_oe_out,
  // received commands
  output logic cmd_valid_out,
  input wire logic cmd_ready_in,
  output logic [7:0] cmd_data_out,
  // result byte to return
  input wire logic rsp_valid_in,
  output logic rsp_ready_out,
  input wire logic [7:0] rsp_data_in
);
  import stw_pkg::*;

  // ------------------------------------------------------------
  // link domain, rising edge group
  // ------------------------------------------------------------
  logic lrs1_q, lrst_n;
  logic rdy1_q, rdy2_q, pnd1_q, pnd2_q;
  stw_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d, ones_q, ones_d;
  logic [7:0] sh_q, sh_d, cmd_q, cmd_d;
  logic cmd_tog_q, cmd_tog_d, done_tog_q, done_tog_d, seen_q, seen_d, ok_q, ok_d;
  // falling edge group, except pdat_q, which is taken on the rising edge
  logic pdat_q, pdat_d, fall_q, fall_d, strt_tog_q, strt_tog_d, drv_q, drv_d;
  logic tx_bit;
  // system domain
  logic [7:0] rsp_q, rsp_d;
  logic pend_q, pend_d;
  logic c1_q, c2_q, c3_q, d1_q, d2_q, d3_q;
  logic push, fifo_ready;

  // reset reaches the link only while the host clocks it; fine, nothing runs otherwise
  always_ff @(posedge sck_in) begin
    lrs1_q <= rst_n_in;
    lrst_n <= lrs1_q;
    rdy1_q <= fifo_ready;
    rdy2_q <= rdy1_q;
    pnd1_q <= pend_q;
    pnd2_q <= pnd1_q;
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    cmd_d = cmd_q;
    cmd_tog_d = cmd_tog_q;
    done_tog_d = done_tog_q;
    seen_d = seen_q;
    ok_d = ok_q;
    ones_d = (dat_in && !drv_q && ones_q != `STW_RESET_EDGES) ? ones_q + 4'h1 : ones_q;
    if (!dat_in || drv_q) begin
      ones_d = 4'h0;
    end
    if (strt_tog_q != seen_q) begin
      seen_d = strt_tog_q;
      state_d = ST_CMD;
      sh_d = {7'h00, dat_in};
      cnt_d = 4'h1;
    end else begin
      case (state_q)
        ST_CMD: begin
          sh_d = {sh_q[6:0], dat_in};
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == `STW_BYTE_BITS - 4'h1) begin
            // only address zero is acknowledged, and only with room to keep it
            ok_d = (sh_q[6:4] == `STW_ADDR_OK) && rdy2_q;
            state_d = ST_ACK;
            if ((sh_q[6:4] == `STW_ADDR_OK) && rdy2_q) begin
              cmd_d = {sh_q[6:0], dat_in};
              cmd_tog_d = !cmd_tog_q;
            end
          end
        end
        ST_ACK: begin
          cnt_d = 4'h0;
          state_d = (ok_q && pnd2_q) ? ST_SEND : ST_IDLE;
        end
        ST_SEND: begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == `STW_BYTE_BITS - 4'h1) begin
            state_d = ST_HACK;
            done_tog_d = !done_tog_q;
          end
        end
        ST_HACK: state_d = ST_IDLE;
        default: state_d = ST_IDLE;
      endcase
      if (ones_q == `STW_RESET_EDGES) begin
        state_d = ST_IDLE;
      end
    end
  end

  always_ff @(posedge sck_in) begin
    if (!lrst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      ones_q <= 4'h0;
      sh_q <= 8'h00;
      cmd_q <= 8'h00;
      cmd_tog_q <= 1'b0;
      done_tog_q <= 1'b0;
      seen_q <= 1'b0;
      ok_q <= 1'b0;
      pdat_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ones_q <= ones_d;
      sh_q <= sh_d;
      cmd_q <= cmd_d;
      cmd_tog_q <= cmd_tog_d;
      done_tog_q <= done_tog_d;
      seen_q <= seen_d;
      ok_q <= ok_d;
      pdat_q <= pdat_d;
    end
  end
  assign pdat_d = dat_in;

  // ------------------------------------------------------------
  // link domain, falling edge group
  // ------------------------------------------------------------
  // rsp_q is held steady while pend_q is set, so reading it here is safe
  assign tx_bit = rsp_q[3'h7 - cnt_q[2:0]];

  always_comb begin
    // a data change inside a high phase is framing, never a data bit
    fall_d = pdat_q && !dat_in;
    strt_tog_d = (fall_q && !pdat_q && dat_in) ? !strt_tog_q : strt_tog_q;
    case (state_q)
      ST_ACK: drv_d = ok_q;
      ST_SEND: drv_d = (cnt_q < `STW_BYTE_BITS) && !tx_bit;
      default: drv_d = 1'b0;
    endcase
  end

  always_ff @(negedge sck_in) begin
    if (!lrst_n) begin
      fall_q <= 1'b0;
      strt_tog_q <= 1'b0;
      drv_q <= 1'b0;
    end else begin
      fall_q <= fall_d;
      strt_tog_q <= strt_tog_d;
      drv_q <= drv_d;
    end
  end

  // pin only ever pulled low, released otherwise
  assign dat_out = 1'b0;
  assign dat_oe_out = drv_q;

  // ------------------------------------------------------------
  // system domain
  // ------------------------------------------------------------
  assign push = c3_q ^ c2_q;
  assign rsp_ready_out = !pend_q;

  always_comb begin
    rsp_d = rsp_q;
    pend_d = pend_q;
    if (d3_q ^ d2_q) begin
      pend_d = 1'b0;
    end
    if (rsp_valid_in && !pend_q) begin
      rsp_d = rsp_data_in;
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      c1_q <= 1'b0;
      c2_q <= 1'b0;
      c3_q <= 1'b0;
      d1_q <= 1'b0;
      d2_q <= 1'b0;
      d3_q <= 1'b0;
      rsp_q <= 8'h00;
      pend_q <= 1'b0;
    end else begin
      c1_q <= cmd_tog_q;
      c2_q <= c1_q;
      c3_q <= c2_q;
      d1_q <= done_tog_q;
      d2_q <= d1_q;
      d3_q <= d2_q;
      rsp_q <= rsp_d;
      pend_q <= pend_d;
    end
  end

  // cmd_q stays put for at least eight link clocks after its toggle
  stw_fifo #(.WIDTH(8), .DEPTH(`STW_FIFO_DEPTH)) u_fifo (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .in_data_in(cmd_q),
    .out_valid_out(cmd_valid_out),
    .out_ready_in(cmd_ready_in),
    .out_data_out(cmd_data_out)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  pin_low_only_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) dat_out == 1'b0)
    else $error("data pin driven high");
  bit_advance_a: assert property (@(posedge sck_in) disable iff (!lrst_n)
    (state_q == ST_CMD && cnt_q < 4'h7 && strt_tog_q == seen_q && ones_q != 4'h9) |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("bit position did not advance by one");
  rise_sample_a: assert property (@(posedge sck_in) disable iff (!lrst_n)
    (state_q == ST_CMD && strt_tog_q == seen_q && ones_q != 4'h9) |=> sh_q[0] == $past(dat_in))
    else $error("bit not taken on rising edge");
  // drv_q was loaded at the last falling edge, and state and count have not moved since
  send_bit_a: assert property (@(posedge sck_in) disable iff (!lrst_n)
    (state_q == ST_SEND && cnt_q < 4'h8) |-> drv_q == !tx_bit)
    else $error("result bit wrong after falling edge");
  idle_quiet_a: assert property (@(negedge sck_in) disable iff (!lrst_n)
    (state_q == ST_IDLE) |=> !drv_q)
    else $error("data pulled while idle");
  ack_drive_a: assert property (@(negedge sck_in) disable iff (!lrst_n)
    (state_q == ST_ACK && ok_q) |=> drv_q)
    else $error("no acknowledge after eighth fall");
  link_reset_a: assert property (@(posedge sck_in) disable iff (!lrst_n)
    (ones_q == 4'h9 && strt_tog_q == seen_q) |=> state_q == ST_IDLE)
    else $error("connection reset not honoured");
  cmd_acked_c: cover property (@(negedge sck_in) disable iff (!lrst_n) state_q == ST_ACK && ok_q);
  result_sent_c: cover property (@(posedge sck_in) disable iff (!lrst_n) state_q == ST_HACK);
  link_reset_c: cover property (@(posedge sck_in) disable iff (!lrst_n) ones_q == 4'h9);
  fifo_full_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in) !fifo_ready);
endmodule

/* File: sim/stw_host.sv */
`timescale 1ns/10ps
// ----
// host end of the link
// ----
module stw_host (
  // link pins
  output logic sck_out,
  output logic dat_oe_out,
  input wire logic dat_in
);
  // low phase; raised to park the clock
  int low_ns = 12;
  initial begin
    sck_out = 1'b0;
    dat_oe_out = 1'b0;
  end
  // data moves a hold time after the fall, s taken mid high phase
  task automatic clk(input logic b, output logic s);
    #3 dat_oe_out = ~b;
    #(low_ns) sck_out = 1'b1;
    #7 s = dat_in;
    #8 sck_out = 1'b0;
  endtask
  task automatic start();
    #3 dat_oe_out = 1'b0;
    #12 sck_out = 1'b1;
    #7 dat_oe_out = 1'b1;
    #8 sck_out = 1'b0;
    #15 sck_out = 1'b1;
    #7 dat_oe_out = 1'b0;
    #8 sck_out = 1'b0;
  endtask
  task automatic idle(input int n);
    logic s;
    repeat (n) clk(1'b1, s);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic s);
    for (int i = 7; i >= 0; i--) clk(tx[i], rx[i]);
    clk(1'b1, s);
  endtask
endmodule

/* File: sim/stw_link_tb.sv */
`timescale 1ns/10ps
module stw_link_tb;
  logic mclk_in, rst_n_in, sck, host_oe, dat_w, d_out, d_oe;
  logic cmd_valid_out, cmd_ready_in, rsp_valid_in, rsp_ready_out;
  logic [7:0] cmd_data_out, rsp_data_in;
  logic [7:0] exp_q[$];
  logic [7:0] rsp_q[$];
  bit drain = 1'b1;
  int errors = 0;
  int checked = 0;
  // pull-up unless a party pulls low
  assign dat_w = ~host_oe & (~d_oe | d_out);
  stw_link i_stw_link (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .sck_in(sck), .dat_in(dat_w),
    .dat_out(d_out), .dat_oe_out(d_oe), .cmd_valid_out(cmd_valid_out), .cmd_ready_in(cmd_ready_in),
    .cmd_data_out(cmd_data_out), .rsp_valid_in(rsp_valid_in), .rsp_ready_out(rsp_ready_out),
    .rsp_data_in(rsp_data_in));
  stw_host i_stw_host (.sck_out(sck), .dat_oe_out(host_oe), .dat_in(dat_w));
  // ----
  // helpers
  // ----
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic settle();
    repeat (400) if (exp_q.size() != 0) @(negedge mclk_in);
    check("left", 8'(exp_q.size()), 8'h00);
  endtask
  task automatic offer(input logic [7:0] b);
    @(negedge mclk_in);
    rsp_valid_in = 1'b1;
    rsp_data_in = b;
    rsp_q.push_back(b);
    do @(posedge mclk_in); while (rsp_ready_out !== 1'b1);
    @(negedge mclk_in);
    rsp_valid_in = 1'b0;
    rsp_data_in = ~b;
    @(negedge mclk_in);
    check("busy", {7'h0, rsp_ready_out}, 8'h00);
  endtask
  // full fifo or foreign address must go unanswered
  task automatic cmd(input logic [7:0] c, input bit rd);
    logic [7:0] rx;
    logic s;
    bit ok;
    ok = c[7:5] == 3'h0 && exp_q.size() < 4;
    if (ok) exp_q.push_back(c);
    i_stw_host.start();
    i_stw_host.xfer(c, rx, s);
    check("ack", {7'h0, s}, {7'h0, ~ok});
    if (rd) begin
      i_stw_host.xfer(8'hff, rx, s);
      check("rsp", rx, rsp_q.pop_front());
      repeat (10) @(negedge mclk_in);
      check("free", {7'h0, rsp_ready_out}, 8'h01);
    end else begin
      #5 check("rel", {7'h0, d_oe}, 8'h00);
    end
  endtask
  // ready is chosen first so the pop is predicted with the value the next rising edge sees
  always @(negedge mclk_in) begin
    cmd_ready_in = drain & 1'($urandom);
    if (cmd_valid_out === 1'b1 && cmd_ready_in === 1'b1) begin
      check("cmd", cmd_data_out, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    end
  end
  initial begin
    #200000;
    errors++;
    results();
  end
  initial begin
    logic [7:0] b;
    void'($urandom(2179));
    rst_n_in = 1'b0;
    cmd_ready_in = 1'b0;
    rsp_valid_in = 1'b0;
    rsp_data_in = 8'h00;
    fork
      repeat (16) @(posedge mclk_in);
      i_stw_host.idle(9);
    join
    check("rst", {5'h0, cmd_valid_out, rsp_ready_out, d_oe}, 8'h02);
    @(negedge mclk_in);
    rst_n_in = 1'b1;
    i_stw_host.idle(9);
    // one command has its clock parked low
    for (int i = 0; i < 6; i++) begin
      i_stw_host.low_ns = (i == 2) ? 3000 : 12;
      cmd({3'h0, 5'($urandom)}, 1'b0);
    end
    for (int a = 1; a < 8; a++) cmd({3'(a), 5'($urandom)}, 1'b0);
    settle();
    drain = 1'b0;
    repeat (5) cmd({3'h0, 5'($urandom)}, 1'b0);
    drain = 1'b1;
    settle();
    for (int i = 0; i < 2; i++) begin
      b = i ? 8'($urandom) : 8'h00;
      offer(b);
      cmd({3'h0, 5'($urandom)}, 1'b1);
    end
    // abort mid-byte, then recover
    // the released clocks complete the byte as 0x0f, address zero, so it is still taken
    if (exp_q.size() < 4) exp_q.push_back(8'h0f);
    i_stw_host.start();
    repeat (4) i_stw_host.clk(1'b0, b[0]);
    i_stw_host.idle(9);
    cmd(8'h03, 1'b0);
    settle();
    results();
  end
endmodule
